// File: hdl/dqm_pin_mux.sv
`timescale 1ns/10ps
module dqm_pin_mux (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst_n, // System reset, synchronous
    input wire logic [dqm_pkg::ADDR_W-1:0] reg_addr, // Register index
    input wire logic [dqm_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [dqm_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic test_reset_n_pin, // Test-reset pin level
    output logic test_reset_pullup_en, // Test-reset pad pull-up enable
    output logic tap_reset_n, // Reset to the TAP controller
    input wire logic [1:0] phase_pin_in, // Phase pins level, 0 = A
    output dqm_pkg::dqm_pad_t phase_pad, // Phase pins drive
    output logic [1:0] phase_pullup_en, // Phase pins pull-up enable
    output logic quad0_phase_a_in, // Decoder phase A input
    output logic quad0_phase_b_in, // Decoder phase B input
    input wire dqm_pkg::dqm_timer_t timer_a_drv, // Timer chan0/1 drive
    output logic [1:0] timer_a_chan_in // Timer chan0/1 input
);
    import dqm_pkg::*;

    // Elaboration check; port C fields and seven indices must fit the port
    if (DATA_W <= PHASE_B_BIT || ADDR_W < 3) begin
        $error("dqm_pin_mux: register port too narrow");
    end

    logic trst_sync;
    logic [1:0] pin_sync;
    logic jtag_pu_dis_q;
    logic [1:0] pur_q;
    logic [1:0] gpio_sel_q;
    logic [1:0] timer_sel_q;
    logic [1:0] dir_q;
    logic [1:0] data_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    dqm_pad_t pad_d;
    dqm_pad_t pad_q;
    logic quad_a_q;
    logic quad_b_q;
    logic [1:0] timer_in_q;
    dqm_fn_t fn [2];

    // Pin function from the two select bits; GPIO wins over timer
    function automatic dqm_fn_t pin_fn(input logic gpio, input logic timer);
        if (gpio) begin
            return DQM_FN_GPIO;
        end else if (timer) begin
            return DQM_FN_TIMER;
        end
        return DQM_FN_QUAD;
    endfunction

    // Place a two-bit port C field at lines 4 and 5
    function automatic logic [DATA_W-1:0] place(input logic [1:0] v);
        logic [DATA_W-1:0] w;
        w = '0;
        w[PHASE_A_BIT] = v[0];
        w[PHASE_B_BIT] = v[1];
        return w;
    endfunction

    // Test-reset pin; this path ignores rst_n so a system reset leaves debug alone
    dqm_sync #(.WIDTH(1)) u_trst_sync (
        .clk(clk),
        .async_in(test_reset_n_pin),
        .sync_out(trst_sync)
    );

    // Phase pins come from outside the clock domain
    dqm_sync #(.WIDTH(2)) u_pin_sync (
        .clk(clk),
        .async_in(phase_pin_in),
        .sync_out(pin_sync)
    );

    // TAP reset runs on the system clock, so no test clock edge is needed
    assign tap_reset_n = trst_sync;
    // Host nothing here ties the two resets together
    assign test_reset_pullup_en = ~jtag_pu_dis_q;
    assign phase_pullup_en = pur_q;

    // Boundary-scan pull-up disable register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            jtag_pu_dis_q <= RST_JTAG_PU_DIS;
        end else if (reg_wr && reg_addr == REG_PULLUP_DIS) begin
            jtag_pu_dis_q <= reg_wdata[JTAG_PU_DIS_BIT];
        end
    end

    // Port C pull-up enables, both on after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pur_q <= RST_PUR;
        end else if (reg_wr && reg_addr == REG_PORTC_PUR) begin
            pur_q <= {reg_wdata[PHASE_B_BIT], reg_wdata[PHASE_A_BIT]};
        end
    end

    // Function selects; reset leaves both pins on the decoder
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpio_sel_q <= RST_GPIO_SEL;
            timer_sel_q <= RST_TIMER_SEL;
        end else if (reg_wr) begin
            if (reg_addr == REG_PORTC_GPIO_SEL) begin
                gpio_sel_q <= {reg_wdata[PHASE_B_BIT], reg_wdata[PHASE_A_BIT]};
            end
            if (reg_addr == REG_PORTC_TIMER_SEL) begin
                timer_sel_q <= {reg_wdata[PHASE_B_BIT], reg_wdata[PHASE_A_BIT]};
            end
        end
    end

    // GPIO direction and output data, one bit per pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= RST_DIR;
            data_q <= RST_DATA;
        end else if (reg_wr) begin
            if (reg_addr == REG_PORTC_DIR) begin
                dir_q <= {reg_wdata[PHASE_B_BIT], reg_wdata[PHASE_A_BIT]};
            end
            if (reg_addr == REG_PORTC_DATA) begin
                data_q <= {reg_wdata[PHASE_B_BIT], reg_wdata[PHASE_A_BIT]};
            end
        end
    end

    // Per-pin routing of pad drive
    always_comb begin
        pad_d = '0;
        pad_d.oe_n = 2'h3;
        for (int i = 0; i < 2; i++) begin
            fn[i] = pin_fn(gpio_sel_q[i], timer_sel_q[i]);
            unique case (fn[i])
                DQM_FN_QUAD: begin
                    pad_d.oe_n[i] = 1'b1;
                end
                DQM_FN_TIMER: begin
                    pad_d.out[i] = timer_a_drv.out[i];
                    pad_d.oe_n[i] = ~timer_a_drv.oe[i];
                end
                DQM_FN_GPIO: begin
                    pad_d.out[i] = data_q[i];
                    pad_d.oe_n[i] = ~dir_q[i];
                end
            endcase
        end
    end

    // Pad drive and peripheral inputs from flops; unselected inputs held low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_q <= '{out: 2'h0, oe_n: 2'h3};
            quad_a_q <= 1'b0;
            quad_b_q <= 1'b0;
            timer_in_q <= 2'h0;
        end else begin
            pad_q <= pad_d;
            quad_a_q <= pin_sync[0] & (fn[0] == DQM_FN_QUAD);
            quad_b_q <= pin_sync[1] & (fn[1] == DQM_FN_QUAD);
            timer_in_q[0] <= pin_sync[0] & (fn[0] == DQM_FN_TIMER);
            timer_in_q[1] <= pin_sync[1] & (fn[1] == DQM_FN_TIMER);
        end
    end

    assign phase_pad = pad_q;
    assign quad0_phase_a_in = quad_a_q;
    assign quad0_phase_b_in = quad_b_q;
    assign timer_a_chan_in = timer_in_q;

    // Read decode; unmapped indices read zero
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr)
            REG_PULLUP_DIS: rdata_d[JTAG_PU_DIS_BIT] = jtag_pu_dis_q;
            REG_PORTC_PUR: rdata_d = place(pur_q);
            REG_PORTC_GPIO_SEL: rdata_d = place(gpio_sel_q);
            REG_PORTC_TIMER_SEL: rdata_d = place(timer_sel_q);
            REG_PORTC_DIR: rdata_d = place(dir_q);
            REG_PORTC_DATA: rdata_d = place(data_q);
            REG_PORTC_PINS: rdata_d = place(pin_sync);
            default: rdata_d = '0;
        endcase
    end

    // Read data stand for the one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// File: hdl/dqm_pkg.sv
package dqm_pkg;
    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register indices
    localparam logic [2:0] REG_PULLUP_DIS = 3'h0;
    localparam logic [2:0] REG_PORTC_PUR = 3'h1;
    localparam logic [2:0] REG_PORTC_GPIO_SEL = 3'h2;
    localparam logic [2:0] REG_PORTC_TIMER_SEL = 3'h3;
    localparam logic [2:0] REG_PORTC_DIR = 3'h4;
    localparam logic [2:0] REG_PORTC_DATA = 3'h5;
    localparam logic [2:0] REG_PORTC_PINS = 3'h6;

    // Field positions
    localparam int JTAG_PU_DIS_BIT = 0;
    localparam int PHASE_A_BIT = 4;
    localparam int PHASE_B_BIT = 5;

    // Reset values
    localparam logic RST_JTAG_PU_DIS = 1'b0;
    localparam logic [1:0] RST_PUR = 2'h3;
    localparam logic [1:0] RST_GPIO_SEL = 2'h0;
    localparam logic [1:0] RST_TIMER_SEL = 2'h0;
    localparam logic [1:0] RST_DIR = 2'h0;
    localparam logic [1:0] RST_DATA = 2'h0;

    // Pin function, one-hot
    typedef enum logic [2:0] {
        DQM_FN_QUAD = 3'h1,
        DQM_FN_TIMER = 3'h2,
        DQM_FN_GPIO = 3'h4
    } dqm_fn_t;

    // Pad drive for the two phase pins, index 0 = phase A
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe_n;
    } dqm_pad_t;

    // Timer A channels 0 and 1 as seen by the mux
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } dqm_timer_t;
endpackage

// File: hdl/dqm_sync.sv
`timescale 1ns/10ps
// Two-flop level synchroniser; no reset so it never masks the pin level
module dqm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic [WIDTH-1:0] async_in, // Level from outside the domain
    output logic [WIDTH-1:0] sync_out // Level safe to use
);
    logic [WIDTH-1:0] meta_q;

    // Elaboration check; a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin
        $error("dqm_sync: WIDTH must be at least 1");
    end

    // First stage is read by the second stage only
    always_ff @(posedge clk) begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
endmodule

// File: verif/dqm_host_model.sv
`timescale 1ns/10ps
// Debug host: owns both reset pins; registered so edges stay clean
module dqm_host_model (
    input wire logic clk, // System clock
    input wire logic full_req, // Full hardware reset wanted
    input wire logic dev_req, // Device-only reset wanted
    input wire logic tap_req, // TAP-only reset wanted
    output logic rst_n = 1'b0, // System reset pin
    output logic test_reset_n_pin = 1'b0 // Test-reset pin
);
    // Test reset always joins a full reset, never a device-only one
    always @(posedge clk) begin
        rst_n <= !(full_req || dev_req);
        test_reset_n_pin <= !(full_req || tap_req);
    end
endmodule

// File: verif/dqm_pin_mux_checker.sv
`timescale 1ns/10ps
module dqm_pin_mux_checker (
    input wire logic clk, // System clock
    input wire logic rst_n, // System reset
    input wire logic [dqm_pkg::ADDR_W-1:0] reg_addr, // Register index
    input wire logic [dqm_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic test_reset_n_pin, // Test-reset pin
    input wire logic test_reset_pullup_en, // Test-reset pull-up
    input wire logic tap_reset_n, // TAP reset
    input wire logic [1:0] phase_pin_in, // Phase pin levels
    input wire dqm_pkg::dqm_pad_t phase_pad, // Phase pad drive
    input wire logic [1:0] phase_pullup_en, // Phase pull-ups
    input wire logic quad0_phase_a_in, // Decoder phase A
    input wire logic quad0_phase_b_in // Decoder phase B
);
    import dqm_pkg::*;
    logic [1:0] warm_q = 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Edges since start; the TAP path has no reset, so wait for three edges of history
    always @(posedge clk) begin
        if (warm_q != 2'h3) begin
            warm_q <= warm_q + 2'h1;
        end
    end
    // Pin held low over two samples
    sequence s_trst_low;
        !test_reset_n_pin [*2];
    endsequence
    // Writes to the two pull-up registers
    sequence s_pur_wr;
        reg_wr && reg_addr == REG_PORTC_PUR;
    endsequence
    sequence s_pud_wr;
        reg_wr && reg_addr == REG_PULLUP_DIS;
    endsequence
    // Pads released and every pull-up on
    sequence s_pins_idle;
        test_reset_pullup_en && phase_pullup_en == 2'h3 && phase_pad.oe_n == 2'h3;
    endsequence
    a_tap_follows_pin: assert property (tap_reset_n == $past(test_reset_n_pin, 2))
        else $error("tap reset does not follow pin");
    a_tap_sysrst_free: assert property (disable iff (1'b0) warm_q == 2'h3 && !rst_n |->
        tap_reset_n == $past(test_reset_n_pin, 2))
        else $error("tap reset disturbed by system reset");
    a_tap_low_nosysrst: assert property (s_trst_low |=> !tap_reset_n)
        else $error("tap reset missed a low pin");
    a_trst_pu_write: assert property (s_pud_wr |=>
        test_reset_pullup_en == !$past(reg_wdata[JTAG_PU_DIS_BIT]))
        else $error("test-reset pull-up wrong after write");
    a_pu_a_write: assert property (s_pur_wr |=> phase_pullup_en[0] == $past(reg_wdata[PHASE_A_BIT]))
        else $error("phase A pull-up wrong after write");
    a_pu_b_write: assert property (s_pur_wr |=> phase_pullup_en[1] == $past(reg_wdata[PHASE_B_BIT]))
        else $error("phase B pull-up wrong after write");
    a_quad_a_cause: assert property (quad0_phase_a_in |-> $past(phase_pin_in[0], 3))
        else $error("decoder phase A high without pin");
    a_quad_b_cause: assert property (quad0_phase_b_in |-> $past(phase_pin_in[1], 3))
        else $error("decoder phase B high without pin");
    a_reset_pin_state: assert property ($rose(rst_n) |-> s_pins_idle)
        else $error("pin state after reset wrong");
endmodule
bind dqm_pin_mux dqm_pin_mux_checker chk_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .test_reset_n_pin,
    .test_reset_pullup_en, .tap_reset_n, .phase_pin_in, .phase_pad, .phase_pullup_en, .quad0_phase_a_in,
    .quad0_phase_b_in);

// File: verif/dqm_pin_mux_tb_top.sv
`timescale 1ns/10ps
module dqm_pin_mux_tb_top;
    import dqm_pkg::*;
    logic clk = 1'b0, full_req = 1'b1, dev_req = 1'b0, tap_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic rst_n, trst_n, tpu, tap_n, qa, qb;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] ext = 2'h0, pins, ppu, tin;
    dqm_pad_t pad;
    dqm_timer_t tdrv = '0;
    int err_total = 0, checked = 0, cyc = 0;
    // Pad wins the wire only while it drives
    assign pins = (pad.out & ~pad.oe_n) | (ext & pad.oe_n);
    initial forever #20 clk = ~clk;
    dqm_host_model host_u (.clk(clk), .full_req(full_req), .dev_req(dev_req), .tap_req(tap_req),
        .rst_n(rst_n), .test_reset_n_pin(trst_n));
    dqm_pin_mux dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_reset_n_pin(trst_n), .test_reset_pullup_en(tpu),
        .tap_reset_n(tap_n), .phase_pin_in(pins), .phase_pad(pad), .phase_pullup_en(ppu),
        .quad0_phase_a_in(qa), .quad0_phase_b_in(qb), .timer_a_drv(tdrv), .timer_a_chan_in(tin));
    task conclude;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, generous against the hundred or so cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand one cycle only, then the port falls back to zero
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge clk);
        #1;
        chk(reg_rdata, 8'h00);
    endtask
    task settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Reset state, register defaults and the unmapped slot
    task t_defaults;
        settle();
        chk(tpu, 1'b1);
        chk(ppu, 2'h3);
        chk(pad.oe_n, 2'h3);
        rd(REG_PORTC_PUR, 8'h30);
        rd(REG_PULLUP_DIS, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
    endtask
    // Both phases land on the decoder after reset; pin stimulus moves on an edge
    task t_quad;
        @(posedge clk);
        ext <= 2'b10;
        settle();
        chk({qb, qa}, 2'b10);
        chk(tin, 2'b00);
        @(posedge clk);
        ext <= 2'b01;
        settle();
        chk({qb, qa}, 2'b01);
    endtask
    // Timer drives pads and sees pin A; decoder then starved
    task t_timer;
        @(posedge clk);
        tdrv <= '{out: 2'b01, oe: 2'b11};
        wr(REG_PORTC_TIMER_SEL, 8'h30);
        settle();
        chk(pad.oe_n, 2'b00);
        chk(pad.out, 2'b01);
        chk({qb, qa}, 2'b00);
        chk(tin, 2'b01);
    endtask
    // GPIO beats timer; A out, B in, then the other way round
    task t_gpio;
        @(posedge clk);
        ext <= 2'b10;
        wr(REG_PORTC_GPIO_SEL, 8'h30);
        wr(REG_PORTC_DIR, 8'h10);
        wr(REG_PORTC_DATA, 8'h30);
        settle();
        chk(pad.oe_n, 2'b10);
        chk(pad.out[0], 1'b1);
        rd(REG_PORTC_PINS, 8'h30);
        wr(REG_PORTC_DIR, 8'h20);
        settle();
        chk(pad.oe_n, 2'b01);
    endtask
    task t_pullups;
        wr(REG_PORTC_PUR, 8'h10);
        wr(REG_PULLUP_DIS, 8'h01);
        settle();
        chk(ppu, 2'b01);
        chk(tpu, 1'b0);
    endtask
    // Device reset leaves the TAP; TAP reset leaves the device registers
    task t_resets;
        @(posedge clk);
        dev_req <= 1'b1;
        settle();
        chk(tap_n, 1'b1);
        chk(tpu, 1'b1);
        @(posedge clk);
        dev_req <= 1'b0;
        settle();
        rd(REG_PORTC_PUR, 8'h30);
        wr(REG_PULLUP_DIS, 8'h01);
        @(posedge clk);
        tap_req <= 1'b1;
        settle();
        chk(tap_n, 1'b0);
        rd(REG_PULLUP_DIS, 8'h01);
        @(posedge clk);
        tap_req <= 1'b0;
        settle();
        chk(tap_n, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        full_req <= 1'b0;
        t_defaults();
        t_quad();
        t_timer();
        t_gpio();
        t_pullups();
        t_resets();
        conclude();
    end
endmodule
